//--- core/cies_core.sv
// What this block does
// - Register zero reads zero; writes to it vanish without exception.
// - Memory byte order is caught at reset: 0 little, 1 big.
// - Flip is status bit 25 in user mode; access order is order xor flip.
// - Link flag: reserve sets, return or invalidate clears, store reads.
// - A use right after a load into a general register stalls until the loaded value is written.
// - Size code n means n+1 bytes: 0 byte, 3 word, 7 doubleword.
// - The address names the lowest-addressed byte of the field.
// - Byte lanes come only from size code, low three address bits and access order.
// - Every jump and branch outside a delay slot has exactly one delay slot that always runs.
// - A fault in a delay slot reports the pc of the preceding branch.
// - Misaligned register jump target faults at target fetch.
// - Three coprocessor units, each with two spaces of 32 registers.
// - General spaces of units one and two load and store to memory; control spaces only move.
// - System control unit registers are reached only by moves.
// - Trapping add faults when carries out of bits 30 and 31 differ.
// - Trapping add decodes as 000000, function 100000, shift field 00000.
// - Immediate trapping add sign-extends the immediate, writes target.
// - On overflow the immediate add faults and keeps its target.
// - All operations of an instruction happen in its execute cycle, except the load write, which waits for read data, and a taken redirect, issued in the slot.
`timescale 1ns/1ns
`include "cies_params.svh"
module cies_core
	import cies_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Strap and invalidate
	input  wire logic        bigEndStrap,
	input  wire logic        invalidate,
	// Instruction issue
	input  wire logic        issValid,
	input  wire logic [31:0] issWord,
	input  wire logic [63:0] issPc,
	output logic             issReady,
	// Memory access
	output logic             memValid,
	output logic             memWrite,
	output logic [63:0]      memAddr,
	output logic [2:0]       memSize,
	output logic [7:0]       memLanes,
	output logic             memBigEnd,
	output logic [63:0]      memWrData,
	input  wire logic        memRdValid,
	input  wire logic [63:0] memRdData,
	// Control flow
	output logic             redirValid,
	output logic [63:0]      redirPc,
	output logic             excValid,
	output logic [1:0]       excCode,
	output logic [63:0]      excPc,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdData
);
	// ****************************************
	// Reset and strap synchronisers.
	// ****************************************
	logic rstMeta_q, rstN, strapMeta_q, strapSync_q, caught_q;
	logic memoryByteOrder_q;
	logic [1:0] strapWait_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstN);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_q <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN      <= rstMeta_q;
		end
	end
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			strapMeta_q <= 1'b0;
			strapSync_q <= 1'b0;
		end else begin
			strapMeta_q <= bigEndStrap;
			strapSync_q <= strapMeta_q;
		end
	end
	// The strap is taken once the synchroniser has filled, so the reset
	// value of its flops can never be mistaken for the strap.
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			strapWait_q       <= 2'h0;
			caught_q          <= 1'b0;
			memoryByteOrder_q <= 1'b0;
		end else if (!caught_q) begin
			if (strapWait_q == `STRAP_SETTLE) begin
				caught_q          <= 1'b1;
				memoryByteOrder_q <= strapSync_q;
			end else begin
				strapWait_q <= strapWait_q + 2'h1;
			end
		end
	end

	// ****************************************
	// Architectural state.
	// ****************************************
	logic [63:0] generalReg_q [32];
	logic [63:0] copReg_q [192];
	logic        userMode_q, linkReservationFlag_q, slot_q, taken_q;
	logic [63:0] tgt_q, branchPc_q, exceptionPcReg_q;
	logic        heldValid_q, loadPend_q, ldCop_q;
	logic [31:0] heldWord_q;
	logic [63:0] heldPc_q;
	logic [7:0]  ldDest_q;
	logic [2:0]  ldSize_q;

	logic userOrderFlip, effectiveLoadStoreOrder;
	assign userOrderFlip = copReg_q[`STATUS_IDX][`STATUS_FLIP_BIT]
		& userMode_q;
	assign effectiveLoadStoreOrder = memoryByteOrder_q ^ userOrderFlip;

	// ****************************************
	// Instruction selection and decode.
	// ****************************************
	logic        curValid;
	logic [31:0] w;
	logic [63:0] pc;
	assign curValid = heldValid_q | (issValid & issReady);
	assign w  = heldValid_q ? heldWord_q : issWord;
	assign pc = heldValid_q ? heldPc_q : issPc;

	logic [5:0]  op, fn;
	logic [4:0]  rs, rt, rd, sa;
	logic [63:0] simm, a, b;
	assign op = w[31:26];
	assign rs = w[25:21];
	assign rt = w[20:16];
	assign rd = w[15:11];
	assign sa = w[10:6];
	assign fn = w[5:0];
	assign simm = {{48{w[15]}}, w[15:0]};
	assign a = generalReg_q[rs];
	assign b = generalReg_q[rt];

	cies_op_t    opc;
	logic        trap, useImm, link, cop;
	logic [2:0]  sz;
	logic [1:0]  unit;
	assign unit = op[1:0];
	always_comb begin
		opc = OP_NONE;
		trap = 1'b0;
		useImm = 1'b0;
		link = 1'b0;
		sz = `SIZE_WORD;
		cop = (op[5:2] == `OPC_COP_HI) && (unit != 2'h3);
		unique case (op)
			`OPC_SPECIAL: begin
				if (sa == 5'h00 && fn == `FN_ADD_TRAP) begin
					opc = OP_ARITH;
					trap = 1'b1;
				end else if (sa == 5'h00 && fn == `FN_ADD_WRAP) begin
					opc = OP_ARITH;
				end else if (fn == `FN_JREG || fn == `FN_JREG_LINK) begin
					opc = OP_JREG;
					link = fn[0];
				end
			end
			`OPC_SUM_IMM_TRAP, `OPC_SUM_IMM_WRAP: begin
				opc = OP_ARITH;
				useImm = 1'b1;
				trap = !op[0];
			end
			`OPC_JUMP, `OPC_JUMP_LINK: begin
				opc = OP_JUMP;
				link = op[0];
			end
			`OPC_BR_EQ, `OPC_BR_NE: opc = OP_BRANCH;
			`OPC_LD_BYTE, `OPC_LD_HALF, `OPC_LD_WORD, `OPC_LD_DWORD: begin
				opc = OP_LOAD;
				sz = op[4] ? `SIZE_DWORD : {1'b0, op[1:0]};
			end
			`OPC_ST_BYTE, `OPC_ST_HALF, `OPC_ST_WORD, `OPC_ST_DWORD: begin
				opc = OP_STORE;
				sz = op[4] ? `SIZE_DWORD : {1'b0, op[1:0]};
			end
			`OPC_LD_RESERVE: opc = OP_LOAD_RESERVE;
			`OPC_ST_COND:    opc = OP_COND_STORE;
			default: begin
				if (cop && rs == `COP_RS_CO && fn == `FN_EXC_RETURN
					&& unit == 2'h0)
					opc = OP_EXC_RETURN;
				else if (cop && (rs == `COP_RS_FROM || rs == `COP_RS_CFROM))
					opc = OP_COP_FROM;
				else if (cop && (rs == `COP_RS_TO || rs == `COP_RS_CTO))
					opc = OP_COP_TO;
				// The system control unit has no memory path at all.
				else if (op[5:2] == `OPC_COPLD_HI && unit inside {2'h1, 2'h2})
					opc = OP_COP_LOAD;
				else if (op[5:2] == `OPC_COPST_HI && unit inside {2'h1, 2'h2})
					opc = OP_COP_STORE;
			end
		endcase
	end

	// ****************************************
	// Interlock and execute.
	// ****************************************
	logic isMem, hazard, go;
	assign isMem = opc inside {OP_LOAD, OP_STORE, OP_LOAD_RESERVE,
		OP_COND_STORE, OP_COP_LOAD, OP_COP_STORE};
	// Register jumps read only rs, but the check is kept uniform on purpose.
	assign hazard = loadPend_q && (isMem || (!ldCop_q && ldDest_q != 8'h00
		&& (ldDest_q[4:0] == rs || ldDest_q[4:0] == rt)));
	assign go = curValid && !hazard;

	logic [32:0] sum33;
	logic        ovf, fetchFault, fault;
	logic [63:0] sumOut;
	assign sum33 = {a[31], a[31:0]} + (useImm ? {simm[31], simm[31:0]}
		: {b[31], b[31:0]});
	assign ovf = trap && (sum33[32] ^ sum33[31]);
	assign sumOut = {{32{sum33[31]}}, sum33[31:0]};
	// Fetch of a misaligned target shows up here, not at the jump.
	assign fetchFault = pc[1:0] != 2'b00;
	assign fault = fetchFault || (opc == OP_ARITH && ovf);

	logic        brTake;
	logic [63:0] brTgt;
	always_comb begin
		brTake = 1'b1;
		brTgt = a;
		unique case (opc)
			OP_BRANCH: begin
				brTake = (a == b) ^ op[0];
				brTgt = pc + 64'h0000_0000_0000_0004 + {simm[61:0], 2'b00};
			end
			OP_JUMP: brTgt = {pc[63:28], w[25:0], 2'b00};
			default: brTgt = a;
		endcase
	end

	logic       wrEn;
	logic [4:0] wrIdx;
	logic [63:0] wrVal;
	logic [7:0] cIdx;
	assign cIdx = {unit, rs[1], rd};
	always_comb begin
		wrEn = 1'b0;
		wrIdx = rt;
		wrVal = sumOut;
		if (go && !fault) begin
			unique case (opc)
				OP_ARITH: begin
					wrEn = 1'b1;
					wrIdx = useImm ? rt : rd;
				end
				OP_JUMP, OP_JREG: begin
					wrEn = link;
					wrIdx = (opc == OP_JUMP) ? `LINK_REG : rd;
					wrVal = pc + 64'h0000_0000_0000_0008;
				end
				OP_COND_STORE: begin
					wrEn = 1'b1;
					wrVal = {63'h0, linkReservationFlag_q};
				end
				OP_COP_FROM: begin
					wrEn = 1'b1;
					wrVal = copReg_q[cIdx];
				end
				default: wrEn = 1'b0;
			endcase
		end
	end

	logic [63:0] ldVal;
	always_comb begin
		unique case (ldSize_q)
			`SIZE_BYTE: ldVal = {{56{memRdData[7]}}, memRdData[7:0]};
			`SIZE_HALF: ldVal = {{48{memRdData[15]}}, memRdData[15:0]};
			`SIZE_WORD: ldVal = {{32{memRdData[31]}}, memRdData[31:0]};
			default:    ldVal = memRdData;
		endcase
	end

	// ****************************************
	// Register files.
	// ****************************************
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < 32; i++)
				generalReg_q[i] <= 64'h0000_0000_0000_0000;
		end else begin
			if (memRdValid && loadPend_q && !ldCop_q && ldDest_q != 8'h00)
				generalReg_q[ldDest_q[4:0]] <= ldVal;
			if (wrEn && wrIdx != 5'h00)
				generalReg_q[wrIdx] <= wrVal;
		end
	end
	// Unit zero registers are 32 bits wide; units one and two hold 64.
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < 192; i++)
				copReg_q[i] <= 64'h0000_0000_0000_0000;
		end else begin
			if (memRdValid && loadPend_q && ldCop_q)
				copReg_q[ldDest_q] <= memRdData;
			if (go && !fault && opc == OP_COP_TO)
				copReg_q[cIdx] <= (unit == 2'h0) ? {32'h0, b[31:0]} : b;
		end
	end

	// ****************************************
	// Load tracking and hold slot.
	// ****************************************
	logic isLoad;
	assign isLoad = opc inside {OP_LOAD, OP_LOAD_RESERVE, OP_COP_LOAD};
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			loadPend_q <= 1'b0;
			ldCop_q    <= 1'b0;
			ldDest_q   <= 8'h00;
			ldSize_q   <= `SIZE_BYTE;
		end else if (go && !fault && isLoad) begin
			loadPend_q <= 1'b1;
			ldCop_q    <= opc == OP_COP_LOAD;
			ldDest_q   <= (opc == OP_COP_LOAD) ? {unit, 1'b0, rt} : {2'h0, 1'b0, rt};
			ldSize_q   <= (opc == OP_LOAD) ? sz : `SIZE_WORD;
		end else if (memRdValid) begin
			loadPend_q <= 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			heldValid_q <= 1'b0;
			heldWord_q  <= 32'h0000_0000;
			heldPc_q    <= 64'h0000_0000_0000_0000;
			issReady    <= 1'b0;
		end else begin
			heldValid_q <= curValid && hazard;
			if (!heldValid_q) begin
				heldWord_q <= issWord;
				heldPc_q   <= issPc;
			end
			issReady <= caught_q && !(curValid && hazard);
		end
	end

	// ****************************************
	// Delay slot, exceptions, reservation.
	// ****************************************
	logic isBr;
	assign isBr = opc inside {OP_BRANCH, OP_JUMP, OP_JREG};
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			slot_q     <= 1'b0;
			taken_q    <= 1'b0;
			tgt_q      <= 64'h0000_0000_0000_0000;
			branchPc_q <= 64'h0000_0000_0000_0000;
			redirValid <= 1'b0;
			redirPc    <= 64'h0000_0000_0000_0000;
		end else begin
			redirValid <= 1'b0;
			if (go) begin
				slot_q <= isBr && !fault && !slot_q;
				if (isBr && !fault && !slot_q) begin
					taken_q    <= brTake;
					tgt_q      <= brTgt;
					branchPc_q <= pc;
				end
				if (slot_q && taken_q && !fault) begin
					redirValid <= 1'b1;
					redirPc    <= tgt_q;
				end
			end
		end
	end
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			excValid         <= 1'b0;
			excCode          <= 2'h0;
			excPc            <= 64'h0000_0000_0000_0000;
			exceptionPcReg_q <= 64'h0000_0000_0000_0000;
		end else begin
			excValid <= go && fault;
			if (go && fault) begin
				excCode <= fetchFault ? `EXC_ADDRESS : `EXC_OVERFLOW;
				excPc   <= slot_q ? branchPc_q : pc;
				exceptionPcReg_q <= slot_q ? branchPc_q : pc;
			end
		end
	end
	// A reserve in the same cycle as an invalidate leaves the flag set.
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN)
			linkReservationFlag_q <= 1'b0;
		else if (go && !fault && opc == OP_LOAD_RESERVE)
			linkReservationFlag_q <= 1'b1;
		else if (invalidate || (go && !fault && opc == OP_EXC_RETURN))
			linkReservationFlag_q <= 1'b0;
	end

	// ****************************************
	// Memory request.
	// ****************************************
	cies_lane_if laneBus ();
	cies_lane_map u_lane (.lane(laneBus.map));
	logic [63:0] ea;
	assign ea = a + simm;
	assign laneBus.size = (opc inside {OP_LOAD, OP_STORE}) ? sz : `SIZE_WORD;
	assign laneBus.addr = ea[2:0];
	assign laneBus.bigEnd = effectiveLoadStoreOrder;
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			memValid  <= 1'b0;
			memWrite  <= 1'b0;
			memAddr   <= 64'h0000_0000_0000_0000;
			memSize   <= `SIZE_BYTE;
			memLanes  <= 8'h00;
			memBigEnd <= 1'b0;
			memWrData <= 64'h0000_0000_0000_0000;
		end else begin
			memValid <= go && !fault && isMem && !(opc == OP_COND_STORE
				&& !linkReservationFlag_q);
			memWrite  <= !isLoad;
			memAddr   <= ea;
			memSize   <= laneBus.size;
			memLanes  <= laneBus.lanes;
			memBigEnd <= effectiveLoadStoreOrder;
			memWrData <= (opc == OP_COP_STORE) ? copReg_q[{unit, 1'b0, rt}] : b;
		end
	end

	// ****************************************
	// Register port.
	// ****************************************
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN)
			userMode_q <= `CTRL_RESET;
		else if (regWr && regAddr == `REG_CTRL)
			userMode_q <= regWrData[0];
	end
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN)
			regRdData <= 32'h0000_0000;
		else if (!regRd)
			regRdData <= 32'h0000_0000;
		else begin
			unique case (regAddr)
				`REG_CTRL:   regRdData <= {31'h0, userMode_q};
				`REG_STATE:  regRdData <= {27'h0, slot_q, linkReservationFlag_q,
					effectiveLoadStoreOrder, userOrderFlip, memoryByteOrder_q};
				`REG_EXC_PC: regRdData <= exceptionPcReg_q[31:0];
				default:     regRdData <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Checks.
	// ****************************************
	sequence s_branch_go;
		go && isBr && !fault && !slot_q && brTake;
	endsequence
	sequence s_slot_go;
		go && !fault && slot_q && taken_q;
	endsequence
	a_zero_reg_kept: assert property (
		generalReg_q[0] == 64'h0) else $error("register zero changed");
	a_order_flip_xor: assert property (
		memValid |-> memBigEnd == $past(memoryByteOrder_q
		^ (copReg_q[`STATUS_IDX][`STATUS_FLIP_BIT] & userMode_q)))
		else $error("byte order wrong");
	a_reserve_set: assert property (
		go && !fault && opc == OP_LOAD_RESERVE |=> linkReservationFlag_q)
		else $error("reserve flag not set");
	a_load_use_stall: assert property (
		curValid && hazard |=> !issReady && heldValid_q)
		else $error("no stall on load use");
	a_lane_count: assert property (
		memValid |-> $countones(memLanes) <= 32'(memSize) + 1)
		else $error("too many lanes");
	a_lowest_lane: assert property (
		memValid && !memBigEnd |-> memLanes[memAddr[2:0]])
		else $error("lowest byte lane missing");
	a_lowest_lane_big: assert property (
		memValid && memBigEnd |-> memLanes[3'h7 - memAddr[2:0]])
		else $error("lowest byte lane missing in big order");
	a_branch_slot: assert property (
		s_branch_go |=> slot_q && taken_q && tgt_q == $past(brTgt))
		else $error("delay slot not opened");
	a_delay_redirect: assert property (
		s_slot_go |=> redirValid && redirPc == $past(tgt_q))
		else $error("delay slot redirect lost");
	a_slot_exc_pc: assert property (
		go && fault && slot_q |=> excValid && excPc == $past(branchPc_q))
		else $error("slot fault pc wrong");
	a_ovf_trap: assert property (
		go && opc == OP_ARITH && ovf |=> excValid
		&& excCode == `EXC_OVERFLOW) else $error("overflow not raised");
	a_ovf_keeps_dest: assert property (
		go && opc == OP_ARITH && ovf |-> !wrEn)
		else $error("destination written on overflow");
endmodule // cies_core

//--- core/cies_params.svh
`ifndef CIES_PARAMS_SVH
`define CIES_PARAMS_SVH
// ****************************************
// Opcode and function codes.
// ****************************************
`define OPC_SPECIAL       6'h00
`define OPC_JUMP          6'h02
`define OPC_JUMP_LINK     6'h03
`define OPC_BR_EQ         6'h04
`define OPC_BR_NE         6'h05
`define OPC_SUM_IMM_TRAP  6'h08
`define OPC_SUM_IMM_WRAP  6'h09
`define OPC_LD_BYTE       6'h20
`define OPC_LD_HALF       6'h21
`define OPC_LD_WORD       6'h23
`define OPC_LD_DWORD      6'h37
`define OPC_ST_BYTE       6'h28
`define OPC_ST_HALF       6'h29
`define OPC_ST_WORD       6'h2b
`define OPC_ST_DWORD      6'h3f
`define OPC_LD_RESERVE    6'h30
`define OPC_ST_COND       6'h38
`define OPC_COP_HI        4'h4
`define OPC_COPLD_HI      4'hc
`define OPC_COPST_HI      4'he
`define FN_ADD_TRAP       6'h20
`define FN_ADD_WRAP       6'h21
`define FN_JREG           6'h08
`define FN_JREG_LINK      6'h09
`define FN_EXC_RETURN     6'h18
`define COP_RS_FROM       5'h00
`define COP_RS_CFROM      5'h02
`define COP_RS_TO         5'h04
`define COP_RS_CTO        5'h06
`define COP_RS_CO         5'h10
// ****************************************
// Sizes, fields and register map.
// ****************************************
`define SIZE_BYTE         3'h0
`define SIZE_HALF         3'h1
`define SIZE_WORD         3'h3
`define SIZE_DWORD        3'h7
`define LINK_REG          5'h1f
`define STATUS_IDX        8'h0c
`define STATUS_FLIP_BIT   25
`define EXC_OVERFLOW      2'h1
`define EXC_ADDRESS       2'h2
`define REG_CTRL          8'h00
`define REG_STATE         8'h04
`define REG_EXC_PC        8'h08
`define CTRL_RESET        1'h0
`define LOAD_WAIT_CYCLES  1
`define STRAP_SETTLE      2'h2
`endif

//--- core/cies_pkg.sv
package cies_pkg;
	typedef enum logic [3:0] {
		OP_NONE         = 4'b0000,
		OP_ARITH        = 4'b0001,
		OP_LOAD         = 4'b0010,
		OP_STORE        = 4'b0011,
		OP_LOAD_RESERVE = 4'b0100,
		OP_COND_STORE   = 4'b0101,
		OP_BRANCH       = 4'b0110,
		OP_JREG         = 4'b0111,
		OP_JUMP         = 4'b1000,
		OP_COP_TO       = 4'b1001,
		OP_COP_FROM     = 4'b1010,
		OP_EXC_RETURN   = 4'b1011,
		OP_COP_LOAD     = 4'b1100,
		OP_COP_STORE    = 4'b1101
	} cies_op_t;
endpackage

//--- core/cies_lane_if.sv
`timescale 1ns/1ns
interface cies_lane_if;
	logic [2:0] size;
	logic [2:0] addr;
	logic       bigEnd;
	logic [7:0] lanes;
	modport core (output size, output addr, output bigEnd, input lanes);
	modport map  (input size, input addr, input bigEnd, output lanes);
endinterface

//--- core/cies_lane_map.sv
`timescale 1ns/1ns
module cies_lane_map
	import cies_pkg::*;
(
	// Access description in, lane mask out
	cies_lane_if.map lane
);
	// ****************************************
	// Byte lane selection.
	// ****************************************
	// A field that would run past the doubleword is clipped, not wrapped.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			logic [3:0] k;
			k = lane.bigEnd ? 4'(7 - i) : 4'(i);
			lane.lanes[i] = (k >= {1'b0, lane.addr}) &&
				(k <= {1'b0, lane.addr} + {1'b0, lane.size});
		end
	end
endmodule // cies_lane_map

//--- dv/cies_tb.sv
`timescale 1ns/1ns
`include "cies_params.svh"
module testbench;
	import cies_pkg::*;
	// ****************************************
	// Signals, clock and checking helpers.
	// ****************************************
	logic        mclk, rst_b, bigEndStrap, invalidate;
	logic        issValid, issReady, memRdValid, regWr, regRd;
	logic        memValid, memWrite, memBigEnd, redirValid, excValid, wb;
	logic [31:0] issWord, regWrData, regRdData;
	logic [63:0] issPc, memRdData, memAddr, memWrData, redirPc, excPc;
	logic [63:0] wd, wa;
	logic [7:0]  memLanes, regAddr, wl;
	logic [2:0]  memSize, ws;
	logic [1:0]  excCode;
	int          errors = 0, n_tests = 0, cyc = 0;

	cies_core dut (.mclk, .rst_b, .bigEndStrap, .invalidate, .issValid,
		.issWord, .issPc, .issReady, .memValid, .memWrite, .memAddr,
		.memSize, .memLanes, .memBigEnd, .memWrData, .memRdValid,
		.memRdData, .redirValid, .redirPc, .excValid, .excCode, .excPc,
		.regAddr, .regWrData, .regWr, .regRd, .regRdData);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// A hang in a handshake wait ends here rather than running forever.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			summarize();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic [31:0] it(int op, int rs, int rt, int im);
		return {op[5:0], rs[4:0], rt[4:0], im[15:0]};
	endfunction

	function automatic logic [31:0] rr(int rs, int rt, int rd, int fn);
		return {6'h00, rs[4:0], rt[4:0], rd[4:0], 5'h00, fn[5:0]};
	endfunction

	// Valid stays up on return so that issues can run back to back.
	task automatic iss(input logic [31:0] w, input logic [63:0] pc = 64'h0);
		issValid <= 1'b1;
		issWord <= w;
		issPc <= pc;
		do @(posedge mclk); while (issReady !== 1'b1);
	endtask

	task automatic stop();
		issValid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic mem(input logic [31:0] w, input logic [63:0] d);
		iss(w);
		stop();
		while (memValid !== 1'b1) @(posedge mclk);
		{wd, wa, ws, wl, wb} = {memWrData, memAddr, memSize, memLanes, memBigEnd};
		memRdValid <= !memWrite;
		memRdData <= d;
		@(posedge mclk);
		memRdValid <= 1'b0;
	endtask

	task automatic ld(input int r, input logic [63:0] d);
		mem(it(`OPC_LD_DWORD, 0, r, 0), d);
	endtask

	task automatic sd(input int r, input logic [63:0] e);
		mem(it(`OPC_ST_DWORD, 0, r, 0), 64'h0);
		chk(wd, e);
	endtask

	task automatic xchk(input logic v, input logic [1:0] c, input logic [63:0] p);
		chk(excValid, v);
		if (v) begin
			chk(excCode, c);
			chk(excPc, p);
		end
	endtask

	task automatic rwr(input logic [7:0] a, input logic [31:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rrd(input logic [7:0] a, input logic [31:0] e);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
		chk(regRdData, e);
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic t_order();
		rrd(`REG_STATE, 32'h0000_0005);
		rrd(8'h40, 32'h0000_0000);
		ld(1, 64'h0000_0000_0200_0000);
		iss({6'h10, `COP_RS_TO, 5'h01, 5'h0c, 11'h000});
		stop();
		rwr(`REG_CTRL, 32'h0000_0001);
		rrd(`REG_STATE, 32'h0000_0003);
		sd(1, 64'h0000_0000_0200_0000);
		chk(wb, 1'b0);
		rwr(`REG_CTRL, 32'h0000_0000);
		rrd(`REG_STATE, 32'h0000_0005);
	endtask

	task automatic t_add();
		ld(2, 64'h0000_0000_7fff_ffff);
		ld(3, 64'h0000_0000_0000_0001);
		ld(4, 64'h0000_0000_0000_0005);
		ld(5, 64'hffff_ffff_ffff_fffe);
		iss(rr(2, 3, 4, `FN_ADD_TRAP), 16'h0040);
		stop();
		xchk(1'b1, `EXC_OVERFLOW, 16'h0040);
		sd(4, 16'h0005);
		iss(rr(5, 3, 4, `FN_ADD_TRAP));
		stop();
		xchk(1'b0, 2'h0, 16'h0000);
		sd(4, 64'hffff_ffff_ffff_ffff);
		iss(rr(3, 3, 0, `FN_ADD_TRAP));
		stop();
		sd(0, 16'h0000);
		iss(it(`OPC_SUM_IMM_TRAP, 3, 6, 16'hfffe));
		stop();
		sd(6, 64'hffff_ffff_ffff_ffff);
		iss(it(`OPC_SUM_IMM_TRAP, 2, 6, 16'h0001), 16'h0080);
		stop();
		xchk(1'b1, `EXC_OVERFLOW, 16'h0080);
		sd(6, 64'hffff_ffff_ffff_ffff);
	endtask

	task automatic t_branch();
		iss(it(`OPC_BR_EQ, 0, 0, 16'h0004), 16'h0200);
		iss(it(`OPC_SUM_IMM_TRAP, 0, 7, 16'h0007), 16'h0204);
		stop();
		chk(redirValid, 1'b1);
		chk(redirPc, 16'h0214);
		sd(7, 16'h0007);
		iss({`OPC_JUMP_LINK, 26'h000_0140}, 16'h0500);
		iss(32'h0000_0000, 16'h0504);
		stop();
		chk(redirPc, 16'h0500);
		sd(31, 16'h0508);
		iss(it(`OPC_BR_EQ, 0, 0, 16'h0004), 16'h0300);
		iss(rr(2, 3, 8, `FN_ADD_TRAP), 16'h0304);
		stop();
		xchk(1'b1, `EXC_OVERFLOW, 16'h0300);
		ld(9, 16'h0402);
		iss(rr(9, 0, 0, `FN_JREG), 16'h0400);
		iss(32'h0000_0000, 16'h0404);
		chk(excValid, 1'b0);
		stop();
		chk(redirPc, 16'h0402);
		iss(32'h0000_0000, 16'h0402);
		stop();
		xchk(1'b1, `EXC_ADDRESS, 16'h0402);
	endtask

	task automatic t_lanes();
		int         op[4] = '{`OPC_ST_BYTE, `OPC_ST_HALF, `OPC_ST_WORD, `OPC_ST_DWORD};
		logic [2:0] sz[4] = '{`SIZE_BYTE, `SIZE_HALF, `SIZE_WORD, `SIZE_DWORD};
		int         a[4] = '{5, 6, 4, 0};
		logic [15:0] m;
		// Big-endian strap: byte b of the doubleword sits on lane 7-b.
		for (int i = 0; i < 4; i++) begin
			m = ((16'h0001 << (sz[i] + 4'h1)) - 16'h0001) << (7 - a[i] - sz[i]);
			mem(it(op[i], 0, 3, a[i]), 64'h0);
			chk(ws, sz[i]);
			chk(wa, a[i]);
			chk(wl, m[7:0]);
			chk(wb, 1'b1);
		end
	endtask

	task automatic t_interlock();
		iss(it(`OPC_LD_DWORD, 0, 10, 0));
		iss(rr(10, 10, 11, `FN_ADD_WRAP));
		chk(memValid, 1'b1);
		issValid <= 1'b0;
		memRdValid <= 1'b1;
		memRdData <= 16'h0041;
		@(posedge mclk);
		memRdValid <= 1'b0;
		sd(11, 16'h0082);
	endtask

	task automatic t_cop();
		mem(it({`OPC_COPLD_HI, 2'h1}, 0, 2, 8), 64'h1234_5678_9abc_def0);
		mem(it({`OPC_COPST_HI, 2'h1}, 0, 2, 8), 16'h0000);
		chk(wd, 64'h1234_5678_9abc_def0);
		iss({6'h11, `COP_RS_FROM, 5'h0e, 5'h02, 11'h000});
		stop();
		sd(14, 64'h1234_5678_9abc_def0);
	endtask

	task automatic t_reserve();
		mem(it(`OPC_LD_RESERVE, 0, 12, 0), 64'h0);
		rrd(`REG_STATE, 32'h0000_000d);
		mem(it(`OPC_ST_COND, 0, 13, 0), 64'h0);
		chk(wd, 16'h0000);
		sd(13, 16'h0001);
		mem(it(`OPC_LD_RESERVE, 0, 12, 0), 64'h0);
		invalidate <= 1'b1;
		@(posedge mclk);
		invalidate <= 1'b0;
		rrd(`REG_STATE, 32'h0000_0005);
		iss(it(`OPC_ST_COND, 0, 3, 0));
		stop();
		chk(memValid, 1'b0);
		sd(3, 16'h0000);
		mem(it(`OPC_LD_RESERVE, 0, 12, 0), 64'h0);
		iss({6'h10, `COP_RS_CO, 15'h0000, `FN_EXC_RETURN});
		stop();
		rrd(`REG_STATE, 32'h0000_0005);
	endtask

	initial begin
		{rst_b, invalidate, issValid, memRdValid, regWr, regRd} = '0;
		{issWord, regWrData, regAddr, issPc, memRdData} = '0;
		bigEndStrap = 1'b1;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (8) @(posedge mclk);
		t_order();
		t_add();
		t_branch();
		t_lanes();
		t_cop();
		t_interlock();
		t_reserve();
		summarize();
	end
endmodule // testbench
